/* File: iso_result_pkg.sv */
package iso_result_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_FREQ_HZ   = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;

	// Strobe delay after result update, least time: round up
	localparam int STROBE_DELAY_NS     = 200;
	localparam int STROBE_DELAY_CYCLES =
		(STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Firing pulse width
	localparam int FIRE_PULSE_US     = 25;
	localparam int FIRE_PULSE_CYCLES =
		FIRE_PULSE_US * (CLK_FREQ_HZ / 1_000_000);

	// Power-listen repetition, 800 Hz nominal inside 700..900 Hz
	localparam int CYCLE_RATE_HZ      = 800;
	localparam int CYCLE_PERIOD_CYCLES = CLK_FREQ_HZ / CYCLE_RATE_HZ;
	localparam int POWER_PHASE_CYCLES  = CYCLE_PERIOD_CYCLES * 3 / 4;
	localparam int LISTEN_PHASE_CYCLES =
		CYCLE_PERIOD_CYCLES - POWER_PHASE_CYCLES;

	localparam int CNT_W = 15;
	localparam int DLY_W = 4;
	localparam int FIRE_W = 10;

	// ---------------------------------------------------------------
	// Result word from the isolated side
	// ---------------------------------------------------------------
	// Redundant coding: value, its complement and a repeat of value
	typedef struct packed {
		logic value;
		logic value_n;
		logic value_rep;
	} result_word_t;

	// Window comparator outputs of the zero-cross input
	typedef struct packed {
		logic above_band;
		logic below_band;
		logic crossed_zero;
	} zero_cross_in_t;

	typedef enum logic {
		PH_POWER,
		PH_LISTEN
	} phase_t;

endpackage : iso_result_pkg

/* File: isolated_compare_result_output.sv */
// What this block does
// R01: Update strobe high for one power cycle after a valid result last listen.
// R02: Update strobe drops at the start of the next listen cycle.
// R03: Strobe rises 200 ns after the latched result takes its value.
// R04: Latched result holds last good value; unchanged when nothing arrives.
// R05: Latched result clears to 0 at power-up and on shutdown.
// R06: Result accepted only if its redundancy check passes.
// R07: Zero-cross trigger gives one firing pulse of about 25 us.
// R08: Fire only with result high, on zero crossing after leaving band.
// R09: Outside logic may sample the result on the strobe rising edge.
// R10: Power and listen phases alternate continuously at 700 to 900 Hz.
// R11: No result or update unless isolated supply reached its enable level.
// R12: Zero-cross input synchronised; re-arm only after leaving the band.
`timescale 1ns/100ps
`default_nettype none

module isolated_compare_result_output (
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	// Shutdown, active low pin
	input  wire logic                          power_down_pin_n,
	// Isolated side result during listen
	input  wire logic                          result_arrived,
	input  wire iso_result_pkg::result_word_t  result_word,
	input  wire logic                          isolated_storage_supply_ok,
	// Zero-cross window comparator, asynchronous
	input  wire iso_result_pkg::zero_cross_in_t zero_cross_in,
	// Outputs
	output logic                               listen_phase,
	output logic                               latched_result,
	output logic                               update_strobe,
	output logic                               zero_cross_fire_pulse
);

	// ---------------------------------------------------------------
	// Shutdown synchroniser
	// ---------------------------------------------------------------
	logic [2:0] pd_sync;
	logic       shutdown;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			pd_sync <= 3'h7;
		else
			pd_sync <= {pd_sync[1:0], power_down_pin_n};
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			shutdown <= 1'b0;
		else if (pd_sync[2] == pd_sync[1])
			shutdown <= ~pd_sync[2];
	end

	// ---------------------------------------------------------------
	// Power-listen sequencer
	// ---------------------------------------------------------------
	iso_result_pkg::phase_t             phase;
	logic [iso_result_pkg::CNT_W-1:0]   phase_cnt;
	wire                                phase_end;
	wire                                listen_start;

	assign phase_end = (phase == iso_result_pkg::PH_POWER) ?
		(phase_cnt == iso_result_pkg::CNT_W'(
			iso_result_pkg::POWER_PHASE_CYCLES - 1)) :
		(phase_cnt == iso_result_pkg::CNT_W'(
			iso_result_pkg::LISTEN_PHASE_CYCLES - 1));
	assign listen_start = phase_end && (phase == iso_result_pkg::PH_POWER);

	// Shutdown parks the sequencer in the power phase
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || shutdown)
		begin
			phase     <= iso_result_pkg::PH_POWER;
			phase_cnt <= '0;
		end
		else if (phase_end)
		begin
			phase_cnt <= '0; // [R10]
			case (phase)
				iso_result_pkg::PH_POWER:  phase <= iso_result_pkg::PH_LISTEN;
				iso_result_pkg::PH_LISTEN: phase <= iso_result_pkg::PH_POWER;
				default:                   phase <= iso_result_pkg::PH_POWER;
			endcase
		end
		else
			phase_cnt <= phase_cnt + 1'b1;
	end

	assign listen_phase = (phase == iso_result_pkg::PH_LISTEN);

	// ---------------------------------------------------------------
	// Result qualification
	// ---------------------------------------------------------------
	wire redundancy_ok;
	wire result_good;

	assign redundancy_ok = (result_word.value == result_word.value_rep) &&
		(result_word.value != result_word.value_n); // [R06]
	assign result_good = listen_phase && result_arrived &&
		isolated_storage_supply_ok && redundancy_ok; // [R06] [R11]

	// Held until the listen phase ends; the strobe belongs to the next power
	logic got_result;
	logic pending_value;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || shutdown)
		begin
			got_result    <= 1'b0;
			pending_value <= 1'b0;
		end
		else if (result_good)
		begin
			got_result    <= 1'b1;
			pending_value <= result_word.value;
		end
		else if (listen_start)
			got_result <= 1'b0;
	end

	wire power_start;
	assign power_start = phase_end && listen_phase;

	// ---------------------------------------------------------------
	// Latched result and update strobe
	// ---------------------------------------------------------------
	logic [iso_result_pkg::DLY_W-1:0] strobe_dly;
	logic                             strobe_wait;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || shutdown)
			latched_result <= 1'b0; // [R05]
		else if (power_start && got_result)
			latched_result <= pending_value; // [R04]
	end

	// Strobe follows the result by a fixed delay so it is settled
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || shutdown)
		begin
			strobe_wait <= 1'b0;
			strobe_dly  <= '0;
		end
		else if (power_start && got_result)
		begin
			strobe_wait <= 1'b1;
			strobe_dly  <= '0;
		end
		else if (strobe_wait)
		begin
			if (strobe_dly == iso_result_pkg::DLY_W'(
				iso_result_pkg::STROBE_DELAY_CYCLES - 1))
				strobe_wait <= 1'b0; // [R03]
			strobe_dly <= strobe_dly + 1'b1;
		end
	end

	wire strobe_rise;
	assign strobe_rise = strobe_wait && (strobe_dly == iso_result_pkg::DLY_W'(
		iso_result_pkg::STROBE_DELAY_CYCLES - 1));

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || shutdown)
			update_strobe <= 1'b0;
		else if (listen_start)
			update_strobe <= 1'b0; // [R02]
		else if (strobe_rise)
			update_strobe <= 1'b1; // [R01] [R03] [R09]
	end

	// ---------------------------------------------------------------
	// Zero-cross detector
	// ---------------------------------------------------------------
	logic [2:0] zc_sync [3];
	logic [2:0] zc_stable;

	// Three-stage sampling, a change counts when stages two and three agree
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			zc_sync[0] <= 3'h0;
			zc_sync[1] <= 3'h0;
			zc_sync[2] <= 3'h0;
			zc_stable  <= 3'h0;
		end
		else
		begin
			zc_sync[0] <= zero_cross_in;
			zc_sync[1] <= zc_sync[0];
			zc_sync[2] <= zc_sync[1];
			for (int i = 0; i < 3; i++)
				if (zc_sync[1][i] == zc_sync[2][i])
					zc_stable[i] <= zc_sync[2][i]; // [R12]
		end
	end

	wire zc_out_of_band;
	wire zc_crossed;
	logic zc_cross_prev;
	logic armed;

	assign zc_out_of_band = zc_stable[2] | zc_stable[1];
	assign zc_crossed     = zc_stable[0] && !zc_cross_prev;

	// ---------------------------------------------------------------
	// Firing pulse
	// ---------------------------------------------------------------
	logic [iso_result_pkg::FIRE_W-1:0] fire_cnt;
	wire                               fire_start;

	assign fire_start = armed && zc_crossed && latched_result &&
		(fire_cnt == '0); // [R08]

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			zc_cross_prev <= 1'b0;
			armed         <= 1'b0;
		end
		else
		begin
			zc_cross_prev <= zc_stable[0];
			if (fire_start || (zc_crossed && !zc_out_of_band))
				armed <= 1'b0; // [R12]
			else if (zc_out_of_band)
				armed <= 1'b1; // [R12]
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			fire_cnt              <= '0;
			zero_cross_fire_pulse <= 1'b0;
		end
		else if (fire_start)
		begin
			fire_cnt              <= iso_result_pkg::FIRE_W'(
				iso_result_pkg::FIRE_PULSE_CYCLES - 1);
			zero_cross_fire_pulse <= 1'b1; // [R07]
		end
		else if (fire_cnt != '0)
			fire_cnt <= fire_cnt - 1'b1;
		else
			zero_cross_fire_pulse <= 1'b0; // [R07]
	end

endmodule : isolated_compare_result_output

`default_nettype wire

/* File: isolated_compare_result_output_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module isolated_compare_result_output_asserts (
	// Clock and reset
	input wire logic				core_clk,
	input wire logic				rst_n,
	// Block inputs
	input wire logic				power_down_pin_n,
	input wire logic				result_arrived,
	input wire iso_result_pkg::result_word_t	result_word,
	input wire logic				isolated_storage_supply_ok,
	input wire iso_result_pkg::zero_cross_in_t	zero_cross_in,
	// Block outputs
	input wire logic				listen_phase,
	input wire logic				latched_result,
	input wire logic				update_strobe,
	input wire logic				zero_cross_fire_pulse
);
	// Shutdown restarts the sequencer, so it zeroes the listen count
	logic [15:0]	listen_cnt;
	logic [15:0]	fire_cnt;
	always_ff @(posedge core_clk)
	begin
		listen_cnt <= (rst_n && power_down_pin_n && listen_phase) ?
			listen_cnt + 16'h1 : 16'h0;
		fire_cnt <= (rst_n && zero_cross_fire_pulse) ?
			fire_cnt + 16'h1 : 16'h0;
	end
	// Expected cause of a strobe: a good word seen in the last listen
	logic	good_now;
	logic	listen_prev;
	logic	saw_good;
	assign good_now = listen_phase && result_arrived &&
		isolated_storage_supply_ok &&
		(result_word.value == result_word.value_rep) &&
		(result_word.value != result_word.value_n);
	always_ff @(posedge core_clk)
	begin
		listen_prev <= listen_phase;
		if (!rst_n)
			saw_good <= 1'b0;
		else if (listen_phase && !listen_prev)
			saw_good <= good_now;
		else if (good_now)
			saw_good <= 1'b1;
	end
	default clocking dclk @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_listen_end;
		listen_phase ##1 !listen_phase;
	endsequence
	AST_STROBE_EARLY:
		assert property (s_listen_end |-> (!update_strobe) [*4])
		else $error("strobe too early");
	AST_STROBE_LATE:
		assert property ($rose(update_strobe) |->
			$past(listen_phase, 5) && !$past(listen_phase, 4))
		else $error("strobe off its delay");
	AST_STROBE_CAUSE:
		assert property ($rose(update_strobe) |-> saw_good)
		else $error("strobe without a good result");
	AST_SHUTDOWN_CLEAR:
		assert property ((!power_down_pin_n) [*7] |->
			!latched_result && !update_strobe)
		else $error("shutdown left result or strobe set");
	AST_STROBE_DROP:
		assert property ($rose(listen_phase) |-> !update_strobe)
		else $error("strobe high in listen");
	AST_STROBE_HOLD:
		assert property (disable iff (!rst_n || !power_down_pin_n)
			$fell(update_strobe) |-> $rose(listen_phase))
		else $error("strobe fell in power phase");
	AST_RESULT_HOLD:
		assert property ($changed(latched_result) |-> !listen_phase
			&& ($past(listen_phase) || !latched_result))
		else $error("result moved off listen end");
	AST_LISTEN_LEN:
		assert property (disable iff (!rst_n || !power_down_pin_n)
			$fell(listen_phase) |->
			listen_cnt == 16'(iso_result_pkg::LISTEN_PHASE_CYCLES))
		else $error("listen length wrong");
	AST_FIRE_WIDTH:
		assert property ($fell(zero_cross_fire_pulse) |->
			fire_cnt == 16'(iso_result_pkg::FIRE_PULSE_CYCLES))
		else $error("fire pulse width wrong");
	AST_FIRE_RESULT:
		assert property ($rose(zero_cross_fire_pulse) |->
			$past(latched_result))
		else $error("fire with result low");
endmodule : isolated_compare_result_output_asserts
`default_nettype wire

/* File: strobe_capture_model.sv */
`timescale 1ns/100ps
`default_nettype none
module strobe_capture_model (
	// From the block
	input wire logic	update_strobe,
	input wire logic	latched_result,
	// Value held outside
	output var logic	captured
);
	initial
	begin
		captured = 1'h0;
		forever
			@(posedge update_strobe) captured <= latched_result;
	end
endmodule : strobe_capture_model
`default_nettype wire

/* File: isolated_compare_result_output_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module isolated_compare_result_output_tb;
	// Row: word, supply ok, result, strobe; row 1 lacks supply
	logic [5:0]	rows [2] = '{6'h2F, 6'h12};
	logic	core_clk = 1'h0;
	logic	rst_n = 1'h0;
	logic	power_down_pin_n = 1'h1;
	logic	result_arrived = 1'h0;
	logic	isolated_storage_supply_ok = 1'h0;
	iso_result_pkg::result_word_t	result_word = 3'h0;
	iso_result_pkg::zero_cross_in_t	zero_cross_in = 3'h0;
	logic	listen_phase;
	logic	latched_result;
	logic	update_strobe;
	logic	zero_cross_fire_pulse;
	logic	captured;
	int	error_cnt = 0;
	int	n_checks = 0;
	int	cycles = 0;
	int	w;
	int	i;
	always #25 core_clk = ~core_clk;
	isolated_compare_result_output isolated_compare_result_output_i (
		.core_clk(core_clk), .rst_n(rst_n),
		.power_down_pin_n(power_down_pin_n),
		.result_arrived(result_arrived), .result_word(result_word),
		.isolated_storage_supply_ok(isolated_storage_supply_ok),
		.zero_cross_in(zero_cross_in), .listen_phase(listen_phase),
		.latched_result(latched_result), .update_strobe(update_strobe),
		.zero_cross_fire_pulse(zero_cross_fire_pulse)
	);
	strobe_capture_model strobe_capture_model_i (
		.update_strobe(update_strobe), .latched_result(latched_result),
		.captured(captured)
	);
	task check(input string nm, input logic [15:0] exp, logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task close_out();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	task fire_test(input logic [2:0] arm, input int exp);
		@(posedge core_clk) zero_cross_in <= arm;
		repeat (8) @(posedge core_clk);
		zero_cross_in <= 3'h1;
		w = 0;
		repeat (600)
		begin
			@(negedge core_clk);
			if (zero_cross_fire_pulse === 1'h1) w++;
		end
		check("fire cycles", 16'(exp), 16'(w));
		$display("fire test done");
	endtask : fire_test
	// Whole run is about 52500 cycles
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			error_cnt++;
			close_out();
		end
	end
	initial
	begin
		@(negedge core_clk);
		check("reset result", 16'h0, 16'(latched_result));
		@(posedge core_clk) rst_n <= 1'h1;
		$display("reset test done");
		for (i = 0; i < 2; i++)
		begin
			while (listen_phase !== 1'h1) @(negedge core_clk);
			check("listen strobe", 16'h0, 16'(update_strobe));
			@(posedge core_clk);
			result_arrived <= 1'h1;
			result_word <= rows[i][5:3];
			isolated_storage_supply_ok <= rows[i][2];
			// Broken redundancy right after must not win
			@(posedge core_clk);
			result_word <= 3'h0;
			isolated_storage_supply_ok <= 1'h1;
			@(posedge core_clk);
			result_arrived <= 1'h0;
			while (listen_phase !== 1'h0) @(negedge core_clk);
			check("result", 16'(rows[i][1]), 16'(latched_result));
			repeat (3) @(negedge core_clk);
			check("early strobe", 16'h0, 16'(update_strobe));
			@(negedge core_clk);
			check("strobe", 16'(rows[i][0]), 16'(update_strobe));
			check("captured", 16'(rows[i][1]), 16'(captured));
			$display("row %0d done", i);
		end
		fire_test(3'h4, iso_result_pkg::FIRE_PULSE_CYCLES);
		fire_test(3'h0, 0);
		fire_test(3'h2, iso_result_pkg::FIRE_PULSE_CYCLES);
		@(posedge core_clk) power_down_pin_n <= 1'h0;
		repeat (10) @(negedge core_clk);
		check("shutdown result", 16'h0, 16'(latched_result));
		$display("shutdown test done");
		@(posedge core_clk) power_down_pin_n <= 1'h1;
		fire_test(3'h4, 0);
		close_out();
	end
endmodule : isolated_compare_result_output_tb
bind isolated_compare_result_output isolated_compare_result_output_asserts
	chk_i (.core_clk(core_clk), .rst_n(rst_n),
	.power_down_pin_n(power_down_pin_n), .result_arrived(result_arrived),
	.result_word(result_word), .zero_cross_in(zero_cross_in),
	.isolated_storage_supply_ok(isolated_storage_supply_ok),
	.listen_phase(listen_phase), .latched_result(latched_result),
	.update_strobe(update_strobe),
	.zero_cross_fire_pulse(zero_cross_fire_pulse));
`default_nettype wire
